// ### hdl/gpio_pkg.sv
// Purpose: constants shared by the general purpose port bank
// Assumes: one 50 MHz clock, synchronous active high reset
// Notes:   register indices sit on a 3-bit plain register port
// Summary of operation
// - eight pins, one control bit each
// - direction one turns the driver off
// - direction zero drives the latch bit
// - level read gives pins, write hits latch
// - bit set/clear writes are read-modify-write
// - latch keeps last latch, level or bit set/clear write
// - direction gates drivers of analog pins too
// - analog pins read zero, also in RMW
// - analog select never changes output drive
// - analog select resets to analog mode
// - open-drain only sinks, else push-pull
// - serial bus ownership forces open-drain
// - output source defaults to the latch
// - analog output forces driver high-impedance
package gpio_pkg;

  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned ADDR_W    = 3;

  // register indices on the plain port
  localparam logic [2:0] LEVEL_IDX  = 3'h0;
  localparam logic [2:0] LATCH_IDX  = 3'h1;
  localparam logic [2:0] DIR_IDX    = 3'h2;
  localparam logic [2:0] ANSEL_IDX  = 3'h3;
  localparam logic [2:0] ODSEL_IDX  = 3'h4;
  localparam logic [2:0] BSET_IDX   = 3'h5;
  localparam logic [2:0] BCLR_IDX   = 3'h6;

  // values after reset
  localparam logic [7:0] DIR_RST    = 8'hFF;
  localparam logic [7:0] LATCH_RST  = 8'h00;
  localparam logic [7:0] ANSEL_RST  = 8'hFF;
  localparam logic [7:0] ODSEL_RST  = 8'h00;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  // latency from control change to pin outputs, in cycles
  localparam int unsigned DRIVE_LAT = 1;

  // what the read/write strobe pair is doing this cycle
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_READ,
    ACC_WRITE
  } access_type;

endpackage

// ### hdl/pin_input_stage.sv
// Purpose: samples the pins and hides analog ones from digital reads
// Assumes: pin inputs are synchronous to clk
// Notes:   masking is after the sample, so it reacts at once
`timescale 1ns/1ps
`default_nettype none
module pin_input_stage
  import gpio_pkg::*;
(
  // clock and control
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // pins and analog select
  input  wire logic [7:0] pin_in,
  input  wire logic [7:0] analog_sel,
  // sampled and masked levels
  output logic      [7:0] raw_level,
  output logic      [7:0] digital_level
);

  logic [7:0] sample_ff;
  logic [7:0] nxt_sample;

  assign nxt_sample = pin_in;

  // one sample per enabled cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_ff <= ZERO_BYTE;
    end else if (ce) begin
      sample_ff <= nxt_sample;
    end
  end

  // analog pins read as zero for every digital consumer
  assign raw_level     = sample_ff;
  assign digital_level = sample_ff & ~analog_sel;

endmodule
`default_nettype wire

// ### hdl/pin_drive_cell.sv
// Purpose: output driver control for one pin
// Assumes: open-drain pads are modelled as oe with a zero level
// Notes:   outputs are registered, one cycle after the controls
`timescale 1ns/1ps
`default_nettype none
module pin_drive_cell (
  // clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // per pin settings
  input  wire logic dir_in,
  input  wire logic latch_bit,
  input  wire logic od_sel,
  // other sources on the pin
  input  wire logic twi_own,
  input  wire logic twi_data,
  input  wire logic route_sel,
  input  wire logic route_data,
  input  wire logic aout_en,
  // pad side
  output logic      pad_out,
  output logic      pad_oe
);

  logic src_bit;
  logic od_mode;
  logic drive_en;
  logic nxt_out;
  logic nxt_oe;
  logic out_ff;
  logic oe_ff;

  // source priority: serial bus, routed peripheral, then latch
  assign src_bit  = twi_own ? twi_data :
                    (route_sel ? route_data : latch_bit);
  // serial bus ownership ignores the open-drain select bit
  assign od_mode  = od_sel | twi_own;
  // analog output wins; direction gates even analog pins
  assign drive_en = ~dir_in & ~aout_en;
  // open-drain only pulls low; push-pull drives both levels
  assign nxt_oe   = drive_en & (~od_mode | ~src_bit);
  assign nxt_out  = od_mode ? 1'b0 : src_bit;

  always_ff @(posedge clk) begin
    if (rst) begin
      out_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else if (ce) begin
      out_ff <= nxt_out;
      oe_ff  <= nxt_oe;
    end
  end

  assign pad_out = out_ff;
  assign pad_oe  = oe_ff;

endmodule
`default_nettype wire

// ### hdl/general_io_port_bank.sv
// Purpose: eight pin general purpose port with register access
// Assumes: plain register port, read data the cycle after a read
// Notes:   pin levels and drive are one cycle behind the registers
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module general_io_port_bank
  import gpio_pkg::*;
(
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // pads
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  // serial bus ownership of pins
  input  wire logic [7:0] twi_own,
  input  wire logic [7:0] twi_data,
  // peripheral routing from pin select logic
  input  wire logic [7:0] route_sel,
  input  wire logic [7:0] route_data,
  // analog outputs enabled on pins
  input  wire logic [7:0] aout_en,
  // levels for on-chip digital inputs
  output logic      [7:0] digital_in
);

  // control registers
  logic [7:0] direction_bits_ff;
  logic [7:0] drive_value_hold_ff;
  logic [7:0] analog_select_bits_ff;
  logic [7:0] open_drain_select_bits_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_direction;
  logic [7:0] nxt_latch;
  logic [7:0] nxt_analog;
  logic [7:0] nxt_open_drain;
  logic [7:0] nxt_rdata;

  // sampled pins
  logic [7:0] raw_level;
  logic [7:0] pin_level_reg;

  // address decode
  access_type access;
  logic       hit_level;
  logic       hit_latch;
  logic       hit_dir;
  logic       hit_ansel;
  logic       hit_odsel;
  logic       hit_bset;
  logic       hit_bclr;
  logic       wr_level;
  logic       wr_latch;
  logic       wr_bset;
  logic       wr_bclr;
  logic [7:0] read_mux;
  logic [7:0] rmw_value;

  // input sampling and analog masking
  pin_input_stage u_input (
    .clk           (clk),
    .rst           (rst),
    .ce            (ce),
    .pin_in        (pin_in),
    .analog_sel    (analog_select_bits_ff),
    .raw_level     (raw_level),
    .digital_level (pin_level_reg)
  );

  assign digital_in = pin_level_reg;

  // classify the strobes; the master never raises both
  assign access = reg_wr ? ACC_WRITE : (reg_rd ? ACC_READ : ACC_IDLE);

  // address decode as named wires
  assign hit_level = (reg_addr == LEVEL_IDX);
  assign hit_latch = (reg_addr == LATCH_IDX);
  assign hit_dir   = (reg_addr == DIR_IDX);
  assign hit_ansel = (reg_addr == ANSEL_IDX);
  assign hit_odsel = (reg_addr == ODSEL_IDX);
  assign hit_bset  = (reg_addr == BSET_IDX);
  assign hit_bclr  = (reg_addr == BCLR_IDX);
  assign wr_level  = (access == ACC_WRITE) && hit_level;
  assign wr_latch  = (access == ACC_WRITE) && hit_latch;
  assign wr_bset   = (access == ACC_WRITE) && hit_bset;
  assign wr_bclr   = (access == ACC_WRITE) && hit_bclr;

  // bit set/clear read the masked pins, so an analog pin or a pin
  // pulled away from its latch can lose its latch value; intended
  always_comb begin
    rmw_value = pin_level_reg;
    if (wr_bset) begin
      rmw_value = pin_level_reg | reg_wdata;
    end else if (wr_bclr) begin
      rmw_value = pin_level_reg & ~reg_wdata;
    end
  end

  // next latch: last latch or level write, or an rmw result
  always_comb begin
    nxt_latch = drive_value_hold_ff;
    if (wr_level || wr_latch) begin
      nxt_latch = reg_wdata;
    end else if (wr_bset || wr_bclr) begin
      nxt_latch = rmw_value;
    end
  end

  // plain configuration writes
  assign nxt_direction  = ((access == ACC_WRITE) && hit_dir) ?
                          reg_wdata : direction_bits_ff;
  assign nxt_analog     = ((access == ACC_WRITE) && hit_ansel) ?
                          reg_wdata : analog_select_bits_ff;
  assign nxt_open_drain = ((access == ACC_WRITE) && hit_odsel) ?
                          reg_wdata : open_drain_select_bits_ff;

  // read selection; set/clear and unmapped slots read zero
  always_comb begin
    case (reg_addr)
      LEVEL_IDX: read_mux = pin_level_reg;
      LATCH_IDX: read_mux = drive_value_hold_ff;
      DIR_IDX:   read_mux = direction_bits_ff;
      ANSEL_IDX: read_mux = analog_select_bits_ff;
      ODSEL_IDX: read_mux = open_drain_select_bits_ff;
      default:   read_mux = ZERO_BYTE;
    endcase
  end

  // data stands only in the cycle after the read strobe
  assign nxt_rdata = (access == ACC_READ) ? read_mux : ZERO_BYTE;

  // control registers; all frozen while ce is low
  always_ff @(posedge clk) begin
    if (rst) begin
      direction_bits_ff         <= DIR_RST;
      drive_value_hold_ff       <= LATCH_RST;
      analog_select_bits_ff     <= ANSEL_RST;
      open_drain_select_bits_ff <= ODSEL_RST;
    end else if (ce) begin
      direction_bits_ff         <= nxt_direction;
      drive_value_hold_ff       <= nxt_latch;
      analog_select_bits_ff     <= nxt_analog;
      open_drain_select_bits_ff <= nxt_open_drain;
    end
  end

  // read data register
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= ZERO_BYTE;
    end else if (ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // one driver cell per pin; analog select is not an input here
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      pin_drive_cell u_cell (
        .clk        (clk),
        .rst        (rst),
        .ce         (ce),
        .dir_in     (direction_bits_ff[gi]),
        .latch_bit  (drive_value_hold_ff[gi]),
        .od_sel     (open_drain_select_bits_ff[gi]),
        .twi_own    (twi_own[gi]),
        .twi_data   (twi_data[gi]),
        .route_sel  (route_sel[gi]),
        .route_data (route_data[gi]),
        .aout_en    (aout_en[gi]),
        .pad_out    (pin_out[gi]),
        .pad_oe     (pin_oe[gi])
      );
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_dir_disables: assert property (
    ce |=> ((pin_oe & $past(direction_bits_ff)) == ZERO_BYTE))
    else $error("driver on for a pin set as input");

  chk_drive_latch: assert property (
    (ce && ~direction_bits_ff[0] && ~aout_en[0] && ~twi_own[0]
     && ~route_sel[0] && ~open_drain_select_bits_ff[0])
    |=> (pin_oe[0] && pin_out[0] == $past(drive_value_hold_ff[0])))
    else $error("output pin does not follow latch");

  chk_level_read: assert property (
    (ce && reg_rd && hit_level)
    |=> (reg_rdata == $past(pin_level_reg)))
    else $error("level read returns wrong value");

  // rmw starts from the raw sample with analog pins forced to zero
  chk_rmw_set: assert property (
    (ce && wr_bset)
    |=> (drive_value_hold_ff == (($past(raw_level)
         & ~$past(analog_select_bits_ff)) | $past(reg_wdata))))
    else $error("bit set is not read-modify-write");

  chk_latch_write: assert property (
    (ce && (wr_level || wr_latch)) ##1 (ce && access == ACC_IDLE)
    |=> (drive_value_hold_ff == $past(reg_wdata, 2)))
    else $error("latch lost the last written value");

  chk_analog_zero: assert property (
    (ce && reg_rd && hit_level)
    |=> (reg_rdata == ($past(raw_level) & ~$past(analog_select_bits_ff))))
    else $error("analog pin reads nonzero");

  chk_analog_nodrive: assert property (
    (ce && analog_select_bits_ff[1] && ~direction_bits_ff[1]
     && ~aout_en[1] && ~twi_own[1] && ~route_sel[1]
     && ~open_drain_select_bits_ff[1])
    |=> (pin_oe[1] && pin_out[1] == $past(drive_value_hold_ff[1])))
    else $error("analog select blocked the driver");

  chk_open_drain: assert property (
    ce |=> ((pin_out & ($past(open_drain_select_bits_ff) | $past(twi_own)))
            == ZERO_BYTE))
    else $error("open-drain pin driven high");

  chk_twi_od: assert property (
    (ce && twi_own[2] && twi_data[2] && ~open_drain_select_bits_ff[2])
    |=> ~pin_oe[2] && ~pin_out[2])
    else $error("serial bus pin driven as push-pull");

  chk_aout_hiz: assert property (
    ce |=> ((pin_oe & $past(aout_en)) == ZERO_BYTE))
    else $error("analog output pin still digitally driven");

  chk_route_default: assert property (
    (ce && ~twi_own[3] && ~route_sel[3] && ~direction_bits_ff[3]
     && ~aout_en[3] && ~open_drain_select_bits_ff[3])
    |=> pin_out[3] == $past(drive_value_hold_ff[3]))
    else $error("unrouted pin not sourced by latch");

  chk_reset_vals: assert property (
    $fell(rst) |-> (direction_bits_ff == DIR_RST
                    && analog_select_bits_ff == ANSEL_RST
                    && open_drain_select_bits_ff == ODSEL_RST))
    else $error("control registers wrong after reset");

  cov_level_write: cover property (ce && wr_level ##1 ce && reg_rd);
  cov_rmw_clear:   cover property (ce && wr_bclr);
  cov_od_low:      cover property (pin_oe[0] && open_drain_select_bits_ff[0]);
  cov_twi_owned:   cover property (twi_own[2] && ~pin_oe[2]);

endmodule
`default_nettype wire

// ### verification/pin_board_model.sv
// Purpose: board side of the eight pads of the port bank
// Assumes: every pad has a pull-up resistor on the board
// Notes:   an external driver may hold a released pad at a level
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
  // device side of the pads
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // board drivers
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  // resolved pad level
  output logic      [7:0] pin_in
);
  // device drive wins; undriven pads rise through the pull-up, so a
  // released open-drain pad rises unless a board driver holds it
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en);
endmodule
`default_nettype wire

// ### verification/general_io_port_bank_tb.sv
// Purpose: self-checking bench for the eight pin port bank
// Assumes: pads resolved by pin_board_model with board pull-ups
// Notes:   pad expectations are rebuilt from shadow register values
`timescale 1ns/1ps
`default_nettype none
module general_io_port_bank_tb;
  import gpio_pkg::*;
  logic       clk, rst, ce, reg_wr, reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, digital_in;
  logic [7:0] twi_own, twi_data, route_sel, route_data, aout_en;
  logic [7:0] ext_val, ext_en, s_dir, s_lat, s_an, s_od;
  int         failures, comparisons;

  general_io_port_bank dut_u (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .twi_own(twi_own), .twi_data(twi_data),
    .route_sel(route_sel), .route_data(route_data),
    .aout_en(aout_en), .digital_in(digital_in));

  pin_board_model board_u (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));

  // expected {out, oe}: serial bus, then routing, then latch
  function automatic logic [15:0] exp_drive();
    logic [7:0] d, odm;
    d   = (twi_own & twi_data) | (~twi_own & route_sel & route_data)
        | (~twi_own & ~route_sel & s_lat);
    odm = twi_own | s_od;
    return {~odm & d, ~s_dir & ~aout_en & (~odm | ~d)};
  endfunction

  // expected pad level as the board resolves it
  function automatic logic [7:0] exp_pad();
    logic [15:0] e;
    e = exp_drive();
    return (e[7:0] & e[15:8]) | (~e[7:0] & (~ext_en | ext_val));
  endfunction

  task automatic check(input logic [7:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp, "read data");
  endtask

  // write and keep the shadow copy in step
  task automatic setr(input logic [2:0] a, input logic [7:0] d);
    if (a == DIR_IDX) s_dir = d;
    if (a == LATCH_IDX || a == LEVEL_IDX) s_lat = d;
    if (a == ANSEL_IDX) s_an = d;
    if (a == ODSEL_IDX) s_od = d;
    if (a == BSET_IDX) s_lat = (exp_pad() & ~s_an) | d;
    if (a == BCLR_IDX) s_lat = (exp_pad() & ~s_an) & ~d;
    wr(a, d);
  endtask

  // drive is registered and pins sampled late, so let both settle
  task automatic pads();
    logic [15:0] e;
    repeat (4) @(posedge clk);
    #1;
    e = exp_drive();
    check(pin_oe, e[7:0], "pad enable");
    check(pin_out & e[7:0], e[15:8] & e[7:0], "pad level");
  endtask

  task automatic report_and_stop();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // watchdog against a hung sequence
  initial begin
    #1000000;
    failures++;
    report_and_stop();
  end

  initial begin
    {rst, ce, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, 13'h0000};
    {twi_own, twi_data, route_sel, route_data, aout_en} = 40'h0;
    {ext_val, ext_en} = 16'h0000;
    {s_dir, s_lat, s_an, s_od} = {DIR_RST, LATCH_RST, ANSEL_RST, ODSEL_RST};
    failures = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // values after reset, unmapped index reads zero
    rd(DIR_IDX, 8'hFF);
    rd(LATCH_IDX, 8'h00);
    rd(ANSEL_IDX, 8'hFF);
    rd(ODSEL_IDX, 8'h00);
    rd(3'h7, 8'h00);
    pads();
    // analog pins hide a driven board level
    @(posedge clk);
    ext_en  <= 8'hFF;
    ext_val <= 8'hA5;
    rd(LEVEL_IDX, 8'h00);
    check(digital_in, 8'h00, "digital input");
    // software clears analog select before digital use
    setr(ANSEL_IDX, 8'h00);
    rd(LEVEL_IDX, 8'hA5);
    check(digital_in, 8'hA5, "digital input");
    // a level write lands in the latch, pins stay inputs
    setr(LEVEL_IDX, 8'h3C);
    rd(LATCH_IDX, 8'h3C);
    pads();
    // clock enable low freezes a write
    @(posedge clk);
    ce <= 1'b0;
    wr(LATCH_IDX, 8'hFF);
    ce <= 1'b1;
    rd(LATCH_IDX, 8'h3C);
    // board releases, pins become outputs
    @(posedge clk);
    ext_en <= 8'h00;
    setr(LATCH_IDX, 8'h5A);
    setr(DIR_IDX, 8'h00);
    pads();
    rd(LEVEL_IDX, 8'h5A);
    setr(DIR_IDX, 8'hF0);
    pads();
    // analog input on a driven pin: drive stays, reads give zero
    setr(DIR_IDX, 8'h00);
    setr(ANSEL_IDX, 8'h0F);
    pads();
    rd(LEVEL_IDX, 8'h50);
    // bit set and clear start from the masked pins
    setr(BSET_IDX, 8'h80);
    rd(LATCH_IDX, 8'hD0);
    pads();
    setr(BCLR_IDX, 8'h10);
    rd(LATCH_IDX, 8'hC0);
    // direction kept set on the analog pins
    setr(DIR_IDX, 8'h0F);
    pads();
    // open drain only sinks; released pads rise through the pull-up
    setr(ANSEL_IDX, 8'h00);
    setr(DIR_IDX, 8'h00);
    setr(LATCH_IDX, 8'hC5);
    setr(ODSEL_IDX, 8'h0F);
    pads();
    rd(LEVEL_IDX, 8'hC5);
    // serial bus ownership forces open drain, routing beats latch
    setr(ODSEL_IDX, 8'h00);
    twi_own    <= 8'h07;
    twi_data   <= 8'h05;
    route_sel  <= 8'h30;
    route_data <= 8'h10;
    pads();
    // analog output takes the pad from any digital source
    @(posedge clk);
    aout_en <= 8'h81;
    pads();
    report_and_stop();
  end
endmodule
`default_nettype wire
